// >>> inc/host_packet_pkg.sv
// shared constants, codes and checksum helper for the host packet engine
package host_packet_pkg;

  // ****************************************************************
  // link timing
  // ****************************************************************
  localparam int CLOCK_HZ      = 250_000_000;
  localparam int BAUD_RATE     = 115200;
  localparam int BIT_CYCLES    = (CLOCK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  localparam int DATA_BITS     = 8;
  localparam logic [3:0] STOP_INDEX = 4'h9;   // start bit, eight data bits, one stop bit
  localparam int RESP_TIME_MS  = 250;
  // margin for a report already on the wire when the deadline nears
  localparam int RESP_GUARD_MS = 1;
  localparam int RESP_CYCLES   = (RESP_TIME_MS - RESP_GUARD_MS) * (CLOCK_HZ / 1000);

  // ****************************************************************
  // packet layout
  // ****************************************************************
  localparam int CLASS_MSB = 7;
  localparam int CLASS_LSB = 6;
  localparam int CODE_W    = 6;
  localparam int LEN_W     = 5;
  localparam logic [1:0] CLASS_CMD = 2'h0;
  localparam logic [1:0] CLASS_RSP = 2'h1;
  localparam logic [1:0] CLASS_RPT = 2'h2;
  localparam logic [1:0] CLASS_ERR = 2'h3;
  localparam logic [7:0] MAX_LEN   = 8'h16;

  // ****************************************************************
  // commands and reports
  // ****************************************************************
  localparam logic [CODE_W-1:0] CMD_KEY_CFG     = 6'h17;
  localparam logic [LEN_W-1:0]  KEY_CFG_LEN     = 5'h02;
  localparam logic [7:0]        TYPE_KEY_REPORT = 8'h80;
  localparam int                NUM_KEYS        = 6;
  localparam logic [5:0]        KEY_MASK_RESET  = 6'h3f;
  localparam logic [7:0]        KEY_RELEASE_OFS = 8'h06;

  // ****************************************************************
  // checksum: reflected 16-bit crc
  // ****************************************************************
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;

  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// >>> src/serial_char_port.sv
// byte-wide asynchronous serial receiver and transmitter, 8n1
`timescale 1ns/1ns
`default_nettype none

module serial_char_port #(
  parameter int BIT_CYCLES = 2170
) (
  input  wire logic       i_clock,
  input  wire logic       i_rstn,
  input  wire logic       i_rxd,
  output logic            o_txd,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready
);
  import host_packet_pkg::*;

  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2 - 1);

  // ****************************************************************
  // receiver
  // ****************************************************************
  logic          rx_busy;
  logic [CW-1:0] rx_cnt;
  logic [3:0]    rx_bit;
  logic [7:0]    rx_shift;
  wire           rx_tick = rx_busy && (rx_cnt == '0);

  // sample mid-bit; a start bit that is gone at mid-bit is a glitch, a low stop bit drops the byte
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      rx_busy    <= 1'b0;
      rx_cnt     <= '0;
      rx_bit     <= 4'h0;
      rx_shift   <= 8'h00;
      o_rx_valid <= 1'b0;
      o_rx_data  <= 8'h00;
    end else begin
      o_rx_valid <= 1'b0;
      if (!rx_busy) begin
        if (!i_rxd) begin
          rx_busy <= 1'b1;
          rx_cnt  <= HALF;
          rx_bit  <= 4'h0;
        end
      end else if (rx_tick) begin
        rx_cnt <= FULL;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && i_rxd) begin
          rx_busy <= 1'b0;
        end else if (rx_bit == STOP_INDEX) begin
          rx_busy    <= 1'b0;
          o_rx_valid <= i_rxd;
          o_rx_data  <= rx_shift;
        end else if (rx_bit != 4'h0) begin
          rx_shift <= {i_rxd, rx_shift[7:1]};
        end
      end else begin
        rx_cnt <= rx_cnt - 1'b1;
      end
    end
  end

  // ****************************************************************
  // transmitter
  // ****************************************************************
  logic          tx_busy;
  logic [CW-1:0] tx_cnt;
  logic [3:0]    tx_bit;
  logic [7:0]    tx_shift;

  assign o_tx_ready = !tx_busy;

  // lsb first; ones shifted in behind the data form the stop bit
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      tx_busy  <= 1'b0;
      tx_cnt   <= '0;
      tx_bit   <= 4'h0;
      tx_shift <= 8'hff;
      o_txd    <= 1'b1;
    end else if (!tx_busy) begin
      if (i_tx_valid) begin
        tx_busy  <= 1'b1;
        tx_cnt   <= FULL;
        tx_bit   <= 4'h0;
        tx_shift <= i_tx_data;
        o_txd    <= 1'b0;
      end
    end else if (tx_cnt == '0) begin
      tx_cnt <= FULL;
      if (tx_bit == STOP_INDEX) begin
        tx_busy <= 1'b0;
      end else begin
        o_txd    <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[7:1]};
        tx_bit   <= tx_bit + 4'h1;
      end
    end else begin
      tx_cnt <= tx_cnt - 1'b1;
    end
  end

endmodule

`default_nettype wire

// >>> src/host_packet_protocol_engine.sv
// device-side packet framer: receive, check, acknowledge and report over the serial link
`timescale 1ns/1ns
`default_nettype none

module host_packet_protocol_engine #(
  parameter int RESP_CYCLES = host_packet_pkg::RESP_CYCLES,
  parameter int BIT_CYCLES  = host_packet_pkg::BIT_CYCLES
) (
  input  wire logic                                i_clock,
  input  wire logic                                i_rstn,
  input  wire logic                                i_rxd,
  output logic                                     o_txd,
  input  wire logic [host_packet_pkg::NUM_KEYS-1:0] i_key_press,
  input  wire logic [host_packet_pkg::NUM_KEYS-1:0] i_key_release,
  output logic                                     o_pay_valid,
  output logic [7:0]                               o_pay_data,
  output logic [host_packet_pkg::LEN_W-1:0]         o_pay_index,
  output logic                                     o_cmd_valid,
  output logic [host_packet_pkg::CODE_W-1:0]        o_cmd_code,
  output logic [host_packet_pkg::LEN_W-1:0]         o_cmd_len,
  input  wire logic                                i_ack_valid,
  input  wire logic                                i_ack_error,
  output logic                                     o_busy
);
  import host_packet_pkg::*;

  // ****************************************************************
  // serial character port
  // ****************************************************************
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       port_valid;
  logic [7:0] port_data;
  logic       port_ready;

  serial_char_port #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_port (
    .i_clock    (i_clock),
    .i_rstn     (i_rstn),
    .i_rxd      (i_rxd),
    .o_txd      (o_txd),
    .o_rx_valid (rx_valid),
    .o_rx_data  (rx_data),
    .i_tx_valid (port_valid),
    .i_tx_data  (port_data),
    .o_tx_ready (port_ready)
  );

  // ****************************************************************
  // receive parser
  // ****************************************************************
  typedef enum logic [4:0] {
    R_TYPE = 5'b00001,
    R_LEN  = 5'b00010,
    R_DATA = 5'b00100,
    R_CRCL = 5'b01000,
    R_CRCH = 5'b10000
  } rx_state_t;

  rx_state_t        rx_state;
  logic [7:0]       rx_type;
  logic [LEN_W-1:0] rx_len;
  logic [LEN_W-1:0] rx_idx;
  logic [15:0]      rx_crc;
  logic [7:0]       rx_crc_lo;
  logic [7:0]       rx_pay0;
  logic [7:0]       rx_pay1;
  logic             pkt_good;

  wire [15:0] rx_crc_next = crc_byte(rx_state == R_TYPE ? CRC_INIT : rx_crc, rx_data);
  wire        len_bad     = rx_data > MAX_LEN;
  wire        last_data   = rx_idx == rx_len - 1'b1;
  wire [15:0] rx_crc_got  = {rx_data, rx_crc_lo};
  wire        crc_ok      = rx_crc_got == ~rx_crc;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      rx_state  <= R_TYPE;
      rx_type   <= 8'h00;
      rx_len    <= '0;
      rx_idx    <= '0;
      rx_crc    <= CRC_INIT;
      rx_crc_lo <= 8'h00;
      rx_pay0   <= 8'h00;
      rx_pay1   <= 8'h00;
      pkt_good  <= 1'b0;
    end else begin
      pkt_good <= 1'b0;
      if (rx_valid) begin
        unique case (rx_state)
          R_TYPE: begin
            rx_type  <= rx_data;
            rx_crc   <= rx_crc_next;
            rx_state <= R_LEN;
          end
          R_LEN: begin
            rx_len   <= rx_data[LEN_W-1:0];
            rx_crc   <= rx_crc_next;
            rx_idx   <= '0;
            if (len_bad) begin
              rx_state <= R_TYPE;
            end else if (rx_data == 8'h00) begin
              rx_state <= R_CRCL;
            end else begin
              rx_state <= R_DATA;
            end
          end
          R_DATA: begin
            rx_crc <= rx_crc_next;
            rx_idx <= rx_idx + 1'b1;
            if (rx_idx == '0) begin
              rx_pay0 <= rx_data;
            end
            if (rx_idx == 5'h01) begin
              rx_pay1 <= rx_data;
            end
            if (last_data) begin
              rx_state <= R_CRCL;
            end
          end
          R_CRCL: begin
            rx_crc_lo <= rx_data;
            rx_state  <= R_CRCH;
          end
          R_CRCH: begin
            pkt_good <= crc_ok;
            rx_state <= R_TYPE;
          end
        endcase
      end
    end
  end

  // payload bytes are shown as they arrive; only o_cmd_valid vouches for them
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_pay_valid <= 1'b0;
      o_pay_data  <= 8'h00;
      o_pay_index <= '0;
    end else begin
      o_pay_valid <= rx_valid && (rx_state == R_DATA);
      if (rx_valid && rx_state == R_DATA) begin
        o_pay_data  <= rx_data;
        o_pay_index <= rx_idx;
      end
    end
  end

  // ****************************************************************
  // command handling
  // ****************************************************************
  typedef enum logic [2:0] {
    C_IDLE = 3'b001,
    C_USER = 3'b010,
    C_RESP = 3'b100
  } cmd_state_t;

  localparam int TW = $clog2(RESP_CYCLES + 1);
  localparam logic [TW-1:0] RESP_LAST = TW'(RESP_CYCLES - 1);

  cmd_state_t        cmd_state;
  logic [7:0]        rsp_type;
  logic [TW-1:0]     resp_timer;
  logic [NUM_KEYS-1:0] press_mask;
  logic [NUM_KEYS-1:0] release_mask;
  logic              rsp_taken;

  wire [1:0]        pkt_class = rx_type[CLASS_MSB:CLASS_LSB];
  wire [CODE_W-1:0] pkt_code  = rx_type[CODE_W-1:0];
  // only class 0 is a command
  wire              is_cmd    = pkt_class == CLASS_CMD;
  wire              is_keycfg = is_cmd && (pkt_code == CMD_KEY_CFG);
  wire              keycfg_ok = is_keycfg && (rx_len == KEY_CFG_LEN);
  // a packet arriving while a command is still open is not taken
  wire              accept    = pkt_good && (cmd_state == C_IDLE);
  wire              timed_out = resp_timer == RESP_LAST;

  assign o_busy = cmd_state != C_IDLE;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      cmd_state  <= C_IDLE;
      rsp_type   <= 8'h00;
      resp_timer <= '0;
      o_cmd_valid <= 1'b0;
      o_cmd_code <= '0;
      o_cmd_len  <= '0;
    end else begin
      o_cmd_valid <= 1'b0;
      unique case (cmd_state)
        C_IDLE: begin
          resp_timer <= '0;
          if (accept) begin
            o_cmd_code <= pkt_code;
            o_cmd_len  <= rx_len;
            if (!is_cmd || (is_keycfg && !keycfg_ok)) begin
              rsp_type  <= {CLASS_ERR, pkt_code};
              cmd_state <= C_RESP;
            end else if (keycfg_ok) begin
              rsp_type  <= {CLASS_RSP, pkt_code};
              cmd_state <= C_RESP;
            end else begin
              o_cmd_valid <= 1'b1;
              cmd_state   <= C_USER;
            end
          end
        end
        C_USER: begin
          resp_timer <= resp_timer + 1'b1;
          if (i_ack_valid) begin
            rsp_type  <= {i_ack_error ? CLASS_ERR : CLASS_RSP, o_cmd_code};
            cmd_state <= C_RESP;
          end else if (timed_out) begin
            rsp_type  <= {CLASS_ERR, o_cmd_code};
            cmd_state <= C_RESP;
          end
        end
        C_RESP: begin
          if (rsp_taken) begin
            cmd_state <= C_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      press_mask   <= KEY_MASK_RESET;
      release_mask <= KEY_MASK_RESET;
    end else if (accept && keycfg_ok) begin
      press_mask   <= rx_pay0[NUM_KEYS-1:0];
      release_mask <= rx_pay1[NUM_KEYS-1:0];
    end
  end

  // ****************************************************************
  // key event queue
  // ****************************************************************
  logic [2*NUM_KEYS-1:0] key_pend;
  logic [2*NUM_KEYS-1:0] key_clear;
  logic [7:0]            key_code;
  logic                  key_any;
  logic                  rpt_taken;

  wire [2*NUM_KEYS-1:0] key_set = {i_key_release & release_mask, i_key_press & press_mask};

  // lowest pending event goes first; codes are position plus one
  always_comb begin
    key_code = 8'h00;
    key_any  = 1'b0;
    for (int i = 2 * NUM_KEYS - 1; i >= 0; i--) begin
      if (key_pend[i]) begin
        key_code = 8'(i + 1);
        key_any  = 1'b1;
      end
    end
  end

  assign key_clear = rpt_taken ? ({{(2*NUM_KEYS-1){1'b0}}, 1'b1} << (key_code - 8'h01))
                               : '0;

  // a new event beats the clear of the same bit
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      key_pend <= '0;
    end else begin
      key_pend <= (key_pend & ~key_clear) | key_set;
    end
  end

  // ****************************************************************
  // transmit sequencer
  // ****************************************************************
  typedef enum logic [5:0] {
    T_IDLE = 6'b000001,
    T_TYPE = 6'b000010,
    T_LEN  = 6'b000100,
    T_DATA = 6'b001000,
    T_CRCL = 6'b010000,
    T_CRCH = 6'b100000
  } tx_state_t;

  tx_state_t        tx_state;
  logic [7:0]       tx_type;
  logic             tx_has_data;
  logic [7:0]       tx_data;
  logic [15:0]      tx_crc;

  // responses go ahead of reports, but a report already started is finished first
  assign rsp_taken  = (tx_state == T_IDLE) && (cmd_state == C_RESP);
  assign rpt_taken  = (tx_state == T_IDLE) && (cmd_state != C_RESP) && key_any;
  assign port_valid = tx_state != T_IDLE;
  wire   tx_fire    = port_valid && port_ready;

  assign port_data = (tx_state == T_TYPE) ? tx_type :
                     (tx_state == T_LEN)  ? {7'h00, tx_has_data} :
                     (tx_state == T_DATA) ? tx_data :
                     (tx_state == T_CRCL) ? ~tx_crc[7:0] :
                     (tx_state == T_CRCH) ? ~tx_crc[15:8] : 8'h00;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      tx_state    <= T_IDLE;
      tx_type     <= 8'h00;
      tx_has_data <= 1'b0;
      tx_data     <= 8'h00;
      tx_crc      <= CRC_INIT;
    end else begin
      unique case (tx_state)
        T_IDLE: begin
          tx_crc <= CRC_INIT;
          if (rsp_taken) begin
            tx_type     <= rsp_type;
            tx_has_data <= 1'b0;
            tx_state    <= T_TYPE;
          end else if (rpt_taken) begin
            tx_type     <= TYPE_KEY_REPORT;
            tx_has_data <= 1'b1;
            tx_data     <= key_code;
            tx_state    <= T_TYPE;
          end
        end
        T_TYPE: if (tx_fire) begin
          tx_crc   <= crc_byte(tx_crc, port_data);
          tx_state <= T_LEN;
        end
        T_LEN: if (tx_fire) begin
          tx_crc   <= crc_byte(tx_crc, port_data);
          tx_state <= tx_has_data ? T_DATA : T_CRCL;
        end
        T_DATA: if (tx_fire) begin
          tx_crc   <= crc_byte(tx_crc, port_data);
          tx_state <= T_CRCL;
        end
        T_CRCL: if (tx_fire) begin
          tx_state <= T_CRCH;
        end
        T_CRCH: if (tx_fire) begin
          tx_state <= T_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> tb/host_packet_checker.sv
// port assertions for the packet engine
`timescale 1ns/1ns
`default_nettype none
module host_packet_checker
  import host_packet_pkg::*;
#(
  parameter int RESP_CYCLES = 2000,
  parameter int BIT_CYCLES  = 8
) (
  input wire logic                i_clock,
  input wire logic                i_rstn,
  input wire logic                i_rxd,
  input wire logic                o_txd,
  input wire logic [NUM_KEYS-1:0] i_key_press,
  input wire logic [NUM_KEYS-1:0] i_key_release,
  input wire logic                o_pay_valid,
  input wire logic [7:0]          o_pay_data,
  input wire logic [LEN_W-1:0]    o_pay_index,
  input wire logic                o_cmd_valid,
  input wire logic [CODE_W-1:0]   o_cmd_code,
  input wire logic [LEN_W-1:0]    o_cmd_len,
  input wire logic                i_ack_valid,
  input wire logic                i_ack_error,
  input wire logic                o_busy
);
  // slack allows a report already on the wire plus the answer itself
  localparam int BUSY_LIMIT = RESP_CYCLES + 120 * BIT_CYCLES;
  // an answer made inside waits at most for one report already on the wire
  localparam int RPT_SPAN   = 60 * BIT_CYCLES;
  int tx_cnt;
  int busy_cnt;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // ****************************************************************
  // helper counters: place within a character, age of an open command
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      tx_cnt   <= 0;
      busy_cnt <= 0;
    end else begin
      busy_cnt <= o_busy ? busy_cnt + 1 : 0;
      if (tx_cnt != 0)
        tx_cnt <= (tx_cnt == 10 * BIT_CYCLES) ? 0 : tx_cnt + 1;
      else if (!o_txd)
        tx_cnt <= 1;
    end
  end
  sequence s_cmd_open;
    o_cmd_valid ##0 o_busy;
  endsequence
  sequence s_busy_set;
    $rose(o_busy);
  endsequence
  a_reset_idle: assert property (@(posedge i_clock) disable iff (1'b0)
    !i_rstn |=> o_txd && !o_busy && !o_cmd_valid && !o_pay_valid)
    else $error("outputs not idle after reset");
  a_start_bit: assert property ((tx_cnt == BIT_CYCLES / 2) |-> !o_txd)
    else $error("start bit not low at mid bit");
  a_stop_bit: assert property ((tx_cnt == 9 * BIT_CYCLES + BIT_CYCLES / 2) |-> o_txd)
    else $error("stop bit not high at mid bit");
  a_cmd_opens: assert property (s_cmd_open |=> o_busy)
    else $error("command strobe without open command");
  a_busy_cause: assert property (s_busy_set ##0 !o_cmd_valid |-> ##[1:RPT_SPAN] !o_busy)
    else $error("internal answer not sent in time");
  a_busy_bound: assert property (busy_cnt <= BUSY_LIMIT)
    else $error("command left unanswered too long");
  a_cmd_fields: assert property (o_cmd_valid |->
    o_cmd_len <= MAX_LEN[LEN_W-1:0] && o_cmd_code != CMD_KEY_CFG)
    else $error("bad command handed to user");
  a_pay_index: assert property (o_pay_valid |-> o_pay_index < 5'h16)
    else $error("payload index beyond maximum");
  a_pay_pulse: assert property (o_pay_valid |=> !o_pay_valid)
    else $error("payload strobe longer than one cycle");
endmodule
`default_nettype wire

// >>> tb/host_link_model.sv
// host model: serial sender and receiver with its own checksum
`timescale 1ns/1ns
`default_nettype none
module host_link_model #(
  parameter int BIT_CYCLES = 8
) (
  input  wire logic i_clock,
  input  wire logic i_txd,
  output logic      o_rxd
);
  // unbounded queue, so the host never loses a packet
  // host buffers packets
  logic [7:0] rx_q[$];
  logic [7:0] rx_byte;
  initial o_rxd = 1'b1;
  // ****************************************************************
  // checksum and transmit side
  // ****************************************************************
  // crc over type length payload
  function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[k]) begin
      c = c ^ {8'h00, b[k]};
      for (int i = 0; i < 8; i++) begin
        c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      end
    end
    return ~c;
  endfunction
  // start, eight bits lsb first, stop
  task automatic send_byte(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rxd = f[i];
      repeat (BIT_CYCLES) @(negedge i_clock);
    end
  endtask
  // crc low byte first, right after payload
  task automatic send_pkt(input logic [7:0] b[$], input logic bad);
    logic [15:0] c;
    c = crc_of(b) ^ {15'h0, bad};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    foreach (b[i]) send_byte(b[i]);
  endtask
  // ****************************************************************
  // receive side, sampling at mid bit
  // ****************************************************************
  initial begin
    forever begin
      @(negedge i_txd);
      repeat (BIT_CYCLES / 2) @(negedge i_clock);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(negedge i_clock);
        rx_byte[i] = i_txd;
      end
      repeat (BIT_CYCLES) @(negedge i_clock);
      rx_q.push_back(rx_byte);
    end
  end
endmodule
`default_nettype wire

// >>> tb/host_packet_protocol_engine_test.sv
// self-checking bench: packet engine against the host model
`timescale 1ns/1ns
`default_nettype none
module host_packet_protocol_engine_test;
  import host_packet_pkg::*;
  localparam int BC = 8;
  localparam int RC = 2000;
  logic                i_clock;
  logic                i_rstn;
  logic                i_rxd;
  logic                o_txd;
  logic [NUM_KEYS-1:0] i_key_press;
  logic [NUM_KEYS-1:0] i_key_release;
  logic                o_pay_valid;
  logic [7:0]          o_pay_data;
  logic [LEN_W-1:0]    o_pay_index;
  logic                o_cmd_valid;
  logic [CODE_W-1:0]   o_cmd_code;
  logic [LEN_W-1:0]    o_cmd_len;
  logic                i_ack_valid;
  logic                i_ack_error;
  logic                o_busy;
  logic [7:0]          pay_q[$];
  int                  err_count;
  int                  check_count;
  int                  cmd_hits;
  host_packet_protocol_engine #(.RESP_CYCLES(RC), .BIT_CYCLES(BC)) i_dut (
    .i_clock, .i_rstn, .i_rxd, .o_txd, .i_key_press, .i_key_release,
    .o_pay_valid, .o_pay_data, .o_pay_index, .o_cmd_valid, .o_cmd_code,
    .o_cmd_len, .i_ack_valid, .i_ack_error, .o_busy
  );
  host_link_model #(.BIT_CYCLES(BC)) i_host (.i_clock, .i_txd(o_txd), .o_rxd(i_rxd));
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  // monitor records strobes; tests judge them later
  always @(negedge i_clock) begin
    if (o_cmd_valid === 1'b1) cmd_hits++;
    if (o_pay_valid === 1'b1) pay_q.push_back(o_pay_data);
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task automatic quiet(input string what);
    repeat (100 * BC) @(negedge i_clock);
    chk(what, 16'h0, 16'(i_host.rx_q.size()));
  endtask
  task automatic expect_pkt(input logic [7:0] typ, input logic [7:0] len, input logic [7:0] d0);
    logic [7:0] p[$];
    int n;
    n = 0;
    while (i_host.rx_q.size() < int'(len) + 4 && n < 6000) begin
      @(negedge i_clock);
      n++;
    end
    repeat (int'(len) + 2) p.push_back(i_host.rx_q.pop_front());
    chk("type", typ, p[0]);
    chk("length", len, p[1]);
    if (len != 0) chk("payload", d0, p[2]);
    chk("crc", i_host.crc_of(p), {i_host.rx_q[1], i_host.rx_q[0]});
    repeat (2) void'(i_host.rx_q.pop_front());
  endtask
  task automatic send_cmd(input logic [7:0] b[$]);
    int h;
    int n;
    h = cmd_hits;
    n = 0;
    i_host.send_pkt(b, 1'b0);
    while (cmd_hits == h && n < 40) begin
      @(negedge i_clock);
      n++;
    end
    chk("command strobe", 16'h1, 16'(cmd_hits - h));
  endtask
  task automatic ack(input logic err);
    @(negedge i_clock);
    i_ack_valid = 1'b1;
    i_ack_error = err;
    @(negedge i_clock);
    i_ack_valid = 1'b0;
  endtask
  task automatic key(input logic rel, input int k);
    @(negedge i_clock);
    if (rel) i_key_release[k] = 1'b1;
    else i_key_press[k] = 1'b1;
    @(negedge i_clock);
    i_key_press = '0;
    i_key_release = '0;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_command;
    pay_q.delete();
    send_cmd('{8'h00, 8'h02, 8'ha5, 8'h3c});
    chk("code", 16'h00, 16'(o_cmd_code));
    chk("cmd length", 16'h02, 16'(o_cmd_len));
    chk("payload 0", 16'ha5, 16'(pay_q[0]));
    chk("payload 1", 16'h3c, 16'(pay_q[1]));
    chk("pay index", 16'h01, 16'(o_pay_index));
    chk("busy open", 16'h1, 16'(o_busy));
    ack(1'b0);
    expect_pkt(8'h40, 8'h00, 8'h00);
    chk("busy closed", 16'h0, 16'(o_busy));
    $display("test command done");
  endtask
  task automatic t_errors;
    send_cmd('{8'h05, 8'h00});
    ack(1'b1);
    expect_pkt(8'hc5, 8'h00, 8'h00);
    i_host.send_pkt('{8'h17, 8'h00}, 1'b0);
    expect_pkt(8'hd7, 8'h00, 8'h00);
    for (int i = 1; i < 4; i++) begin
      i_host.send_pkt('{{2'(i), 6'h0b}, 8'h00}, 1'b0);
      expect_pkt(8'hcb, 8'h00, 8'h00);
    end
    $display("test errors done");
  endtask
  task automatic t_drop;
    i_host.send_pkt('{8'h06, 8'h00}, 1'b1);
    i_host.send_byte(8'h02);
    i_host.send_byte(8'h17);
    quiet("silent drop");
    send_cmd('{8'h07, 8'h00});
    ack(1'b0);
    expect_pkt(8'h47, 8'h00, 8'h00);
    $display("test drop done");
  endtask
  // host keeps arrival order: the report comes before the timeout answer
  task automatic t_timeout;
    send_cmd('{8'h09, 8'h00});
    key(1'b0, 0);
    expect_pkt(8'h80, 8'h01, 8'h01);
    expect_pkt(8'hc9, 8'h00, 8'h00);
    ack(1'b0);
    quiet("late ack ignored");
    send_cmd('{8'h09, 8'h00});
    ack(1'b0);
    expect_pkt(8'h49, 8'h00, 8'h00);
    $display("test timeout done");
  endtask
  task automatic t_keys;
    for (int k = 0; k < NUM_KEYS; k++) begin
      key(1'b0, k);
      expect_pkt(8'h80, 8'h01, 8'(k + 1));
      key(1'b1, k);
      expect_pkt(8'h80, 8'h01, 8'(k + 7));
    end
    $display("test keys done");
  endtask
  task automatic t_mask;
    i_host.send_pkt('{8'h17, 8'h02, 8'h00, 8'h3f}, 1'b0);
    expect_pkt(8'h57, 8'h00, 8'h00);
    key(1'b0, 3);
    quiet("masked press");
    key(1'b1, 3);
    expect_pkt(8'h80, 8'h01, 8'h0a);
    i_host.send_pkt('{8'h17, 8'h02, 8'h3f, 8'h3f}, 1'b0);
    expect_pkt(8'h57, 8'h00, 8'h00);
    key(1'b0, 3);
    expect_pkt(8'h80, 8'h01, 8'h04);
    $display("test mask done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // each command waits for its answer
  initial begin
    i_rstn = 1'b0;
    i_key_press = '0;
    i_key_release = '0;
    i_ack_valid = 1'b0;
    i_ack_error = 1'b0;
    repeat (4) @(negedge i_clock);
    i_rstn = 1'b1;
    @(negedge i_clock);
    t_command;
    t_errors;
    t_drop;
    t_timeout;
    t_keys;
    t_mask;
    results;
  end
  // all scenarios need well under this span
  initial begin
    #(80000 * 4);
    err_count++;
    $display("ERROR watchdog expected finish seen timeout");
    results;
  end
endmodule
bind host_packet_protocol_engine host_packet_checker #(
  .RESP_CYCLES(RESP_CYCLES), .BIT_CYCLES(BIT_CYCLES)
) i_chk (
  .i_clock, .i_rstn, .i_rxd, .o_txd, .i_key_press, .i_key_release,
  .o_pay_valid, .o_pay_data, .o_pay_index, .o_cmd_valid, .o_cmd_code,
  .o_cmd_len, .i_ack_valid, .i_ack_error, .o_busy
);
`default_nettype wire
